// *** core/scrb_pkg.sv ***
// package: register map, field layout and codes of the system config bank
package scrb_pkg;

    // register byte offsets
    localparam logic [7:0]  SCRB_OFS_CFG     = 8'h00;
    localparam logic [7:0]  SCRB_OFS_SEL0    = 8'h08;
    localparam logic [7:0]  SCRB_OFS_SEL1    = 8'h0c;
    localparam logic [7:0]  SCRB_OFS_SEL2    = 8'h10;
    localparam logic [7:0]  SCRB_OFS_SEL3    = 8'h14;

    // field positions in the config register
    localparam int unsigned SCRB_BIT_T2_RMP  = 12;
    localparam int unsigned SCRB_BIT_T1_RMP  = 11;
    localparam int unsigned SCRB_BIT_RX_RMP  = 10;
    localparam int unsigned SCRB_BIT_TX_RMP  = 9;
    localparam int unsigned SCRB_BIT_ADC_RMP = 8;
    localparam int unsigned SCRB_MEM_LSB     = 0;
    localparam int unsigned SCRB_MEM_W       = 2;

    // writable bits and reset values
    localparam logic [31:0] SCRB_CFG_MASK    = 32'h0000_1f03;
    localparam logic [31:0] SCRB_SEL_MASK    = 32'h0000_ffff;
    localparam logic [31:0] SCRB_CFG_RST     = 32'h0000_0000;
    localparam logic [31:0] SCRB_SEL_RST     = 32'h0000_0000;

    // external interrupt source codes
    localparam int unsigned SCRB_SEL_W       = 4;
    localparam int unsigned SCRB_LINES       = 16;
    localparam int unsigned SCRB_SEL_PER_REG = 4;
    localparam logic [3:0]  SCRB_SRC_PA      = 4'h0;
    localparam logic [3:0]  SCRB_SRC_PB      = 4'h1;
    localparam logic [3:0]  SCRB_SRC_PC      = 4'h2;
    localparam logic [3:0]  SCRB_SRC_PD      = 4'h3;

    // memory placed at address zero
    typedef enum logic [2:0] {
        SCRB_MEM_MAIN   = 3'b001,
        SCRB_MEM_SYSTEM = 3'b010,
        SCRB_MEM_RAM    = 3'b100
    } scrb_mem_e;

    // dma requests from the requesting peripherals
    typedef struct packed {
        logic second_single_timer_channel_request;
        logic second_single_timer_update_request;
        logic first_single_timer_channel_request;
        logic first_single_timer_update_request;
        logic serial_receive_request;
        logic serial_transmit_request;
        logic converter_request;
    } scrb_dma_req_s;

    // remap selects as seen by the routing
    typedef struct packed {
        logic second_single_timer_dma_remap;
        logic first_single_timer_dma_remap;
        logic serial_receive_dma_remap;
        logic serial_transmit_dma_remap;
        logic converter_dma_remap;
    } scrb_remap_s;

endpackage : scrb_pkg

// *** core/scrb_bank.sv ***
// system configuration bank: dma remap, boot memory select, irq source mux
//
// Function
// - bit 12 moves second timer channel and update requests from dma 1 to 2
// - bit 11 moves first timer channel and update requests from dma 3 to 4
// - bit 10 moves serial receive request from dma channel 3 to 5
// - bit 9 moves serial transmit request from dma channel 2 to 4
// - bit 8 moves converter request from dma channel 1 to 2
// - memory field x0 main flash, 01 system flash, 11 ram at zero
// - memory field loads from boot pin and option bit; software may override
// - four-bit selector per irq line picks port a, b, c or d pin
// - four selectors per register in bits 15:0, lines 0-15 over four regs
//
// Our own choice: the APB register port.
module scrb_bank (
    // clock and reset
    input  wire logic                     core_clk,
    input  wire logic                     rst,
    // apb slave
    input  wire logic                     psel,
    input  wire logic                     penable,
    input  wire logic                     pwrite,
    input  wire logic [7:0]               paddr,
    input  wire logic [31:0]              pwdata,
    input  wire logic [3:0]               pstrb,
    output logic                          pready,
    output logic                          pslverr,
    output logic [31:0]                   prdata,
    // boot straps
    input  wire logic                     boot_select_pin,
    input  wire logic                     inverted_boot_option_bit,
    // dma request routing
    input  wire scrb_pkg::scrb_dma_req_s  dma_req_in,
    output logic [5:1]                    dma_chan_req,
    output scrb_pkg::scrb_remap_s         remap_sel,
    // memory decoder
    output scrb_pkg::scrb_mem_e           mem_select,
    // external interrupt source mux
    input  wire logic [15:0]              gpio_port_a,
    input  wire logic [15:0]              gpio_port_b,
    input  wire logic [15:0]              gpio_port_c,
    input  wire logic [15:0]              gpio_port_d,
    output logic [15:0]                   ext_irq_line
);
    import scrb_pkg::*;

    // register index decode, shared by write and read paths
    function automatic logic [2:0] reg_index(input logic [7:0] addr);
        unique case (addr)
            SCRB_OFS_CFG:   reg_index = 3'h1;
            SCRB_OFS_SEL0:  reg_index = 3'h2;
            SCRB_OFS_SEL1:  reg_index = 3'h3;
            SCRB_OFS_SEL2:  reg_index = 3'h4;
            SCRB_OFS_SEL3:  reg_index = 3'h5;
            default:        reg_index = 3'h0;
        endcase
    endfunction : reg_index

    // byte strobe expansion to a bit mask
    function automatic logic [31:0] strb_mask(input logic [3:0] strb);
        strb_mask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    endfunction : strb_mask

    logic [31:0] cfg_reg;
    logic [31:0] src_sel_reg [4];
    logic        boot_pend_reg;
    logic        boot_meta_reg;
    logic        boot_sync_reg;
    logic [15:0] pa_meta_reg, pb_meta_reg, pc_meta_reg, pd_meta_reg;
    logic [15:0] pa_sync_reg, pb_sync_reg, pc_sync_reg, pd_sync_reg;
    logic [31:0] prdata_reg;
    logic [5:1]  dma_chan_reg;
    logic [15:0] ext_irq_reg;
    logic        wr_en;
    logic        rd_setup;
    logic [2:0]  idx;
    logic [31:0] wmask;
    logic [1:0]  boot_mem;
    logic [15:0] ext_irq_next;
    logic [5:1]  dma_chan_next;

    // bus decode: zero wait state, error on unmapped offsets
    assign idx      = reg_index(paddr);
    assign wr_en    = psel && penable && pwrite && (idx != 3'h0);
    assign rd_setup = psel && !penable;
    assign wmask    = strb_mask(pstrb);
    assign pready   = 1'b1;
    assign pslverr  = psel && penable && (idx == 3'h0);
    assign prdata   = prdata_reg;

    // boot strap pin synchroniser, runs through reset
    always_ff @(posedge core_clk) begin
        boot_meta_reg <= boot_select_pin;
        boot_sync_reg <= boot_meta_reg;
    end

    // gpio pin synchronisers, two stages each
    always_ff @(posedge core_clk) begin
        pa_meta_reg <= gpio_port_a;
        pb_meta_reg <= gpio_port_b;
        pc_meta_reg <= gpio_port_c;
        pd_meta_reg <= gpio_port_d;
        pa_sync_reg <= pa_meta_reg;
        pb_sync_reg <= pb_meta_reg;
        pc_sync_reg <= pc_meta_reg;
        pd_sync_reg <= pd_meta_reg;
    end

    // boot pin low gives main flash, else option bit picks system or ram
    assign boot_mem = {boot_sync_reg & ~inverted_boot_option_bit,
                       boot_sync_reg};

    // strap is caught on the first edge after reset release
    always_ff @(posedge core_clk) begin
        if (rst) begin
            boot_pend_reg <= 1'b1;
        end else begin
            boot_pend_reg <= 1'b0;
        end
    end

    // config register: software write wins over the boot load
    always_ff @(posedge core_clk) begin
        if (rst) begin
            cfg_reg <= SCRB_CFG_RST;
        end else if (wr_en && idx == 3'h1) begin
            cfg_reg <= (cfg_reg & ~(wmask & SCRB_CFG_MASK))
                     | (pwdata & wmask & SCRB_CFG_MASK);
        end else if (boot_pend_reg) begin
            cfg_reg[SCRB_MEM_LSB +: SCRB_MEM_W] <= boot_mem;
        end
    end

    // selector registers, one per four lines
    for (genvar r = 0; r < 4; r++) begin : g_sel_reg
        always_ff @(posedge core_clk) begin
            if (rst) begin
                src_sel_reg[r] <= SCRB_SEL_RST;
            end else if (wr_en && idx == 3'(r + 2)) begin
                src_sel_reg[r] <= (src_sel_reg[r] & ~(wmask & SCRB_SEL_MASK))
                                | (pwdata & wmask & SCRB_SEL_MASK);
            end
        end
    end

    // read data captured in the setup phase
    always_ff @(posedge core_clk) begin
        if (rst) begin
            prdata_reg <= 32'h0000_0000;
        end else if (rd_setup) begin
            unique case (idx)
                3'h1:    prdata_reg <= cfg_reg & SCRB_CFG_MASK;
                3'h2:    prdata_reg <= src_sel_reg[0] & SCRB_SEL_MASK;
                3'h3:    prdata_reg <= src_sel_reg[1] & SCRB_SEL_MASK;
                3'h4:    prdata_reg <= src_sel_reg[2] & SCRB_SEL_MASK;
                3'h5:    prdata_reg <= src_sel_reg[3] & SCRB_SEL_MASK;
                default: prdata_reg <= 32'h0000_0000;
            endcase
        end
    end

    // remap selects straight from the config register
    assign remap_sel.second_single_timer_dma_remap = cfg_reg[SCRB_BIT_T2_RMP];
    assign remap_sel.first_single_timer_dma_remap  = cfg_reg[SCRB_BIT_T1_RMP];
    assign remap_sel.serial_receive_dma_remap      = cfg_reg[SCRB_BIT_RX_RMP];
    assign remap_sel.serial_transmit_dma_remap     = cfg_reg[SCRB_BIT_TX_RMP];
    assign remap_sel.converter_dma_remap           = cfg_reg[SCRB_BIT_ADC_RMP];

    // request routing onto dma channels 1 to 5
    always_comb begin
        logic t2;
        logic t1;
        t2 = dma_req_in.second_single_timer_channel_request
           | dma_req_in.second_single_timer_update_request;
        t1 = dma_req_in.first_single_timer_channel_request
           | dma_req_in.first_single_timer_update_request;
        dma_chan_next[1] = (t2 & ~remap_sel.second_single_timer_dma_remap)
                         | (dma_req_in.converter_request
                            & ~remap_sel.converter_dma_remap);
        dma_chan_next[2] = (t2 & remap_sel.second_single_timer_dma_remap)
                         | (dma_req_in.serial_transmit_request
                            & ~remap_sel.serial_transmit_dma_remap)
                         | (dma_req_in.converter_request
                            & remap_sel.converter_dma_remap);
        dma_chan_next[3] = (t1 & ~remap_sel.first_single_timer_dma_remap)
                         | (dma_req_in.serial_receive_request
                            & ~remap_sel.serial_receive_dma_remap);
        dma_chan_next[4] = (t1 & remap_sel.first_single_timer_dma_remap)
                         | (dma_req_in.serial_transmit_request
                            & remap_sel.serial_transmit_dma_remap);
        dma_chan_next[5] = dma_req_in.serial_receive_request
                         & remap_sel.serial_receive_dma_remap;
    end

    // registered channel requests
    always_ff @(posedge core_clk) begin
        if (rst) begin
            dma_chan_reg <= 5'h00;
        end else begin
            dma_chan_reg <= dma_chan_next;
        end
    end
    assign dma_chan_req = dma_chan_reg;

    // memory select decode from the two-bit field
    always_comb begin
        if (!cfg_reg[SCRB_MEM_LSB]) begin
            mem_select = SCRB_MEM_MAIN;
        end else if (!cfg_reg[SCRB_MEM_LSB + 1]) begin
            mem_select = SCRB_MEM_SYSTEM;
        end else begin
            mem_select = SCRB_MEM_RAM;
        end
    end

    // per-line source mux, unknown codes give a quiet line
    for (genvar l = 0; l < 16; l++) begin : g_sel_mux
        logic [3:0] sel;
        assign sel =
            src_sel_reg[l / 4][(l % 4) * SCRB_SEL_W +: SCRB_SEL_W];
        always_comb begin
            unique case (sel)
                SCRB_SRC_PA: ext_irq_next[l] = pa_sync_reg[l];
                SCRB_SRC_PB: ext_irq_next[l] = pb_sync_reg[l];
                SCRB_SRC_PC: ext_irq_next[l] = pc_sync_reg[l];
                SCRB_SRC_PD: ext_irq_next[l] = pd_sync_reg[l];
                default:     ext_irq_next[l] = 1'b0;
            endcase
        end
    end

    // registered interrupt lines
    always_ff @(posedge core_clk) begin
        if (rst) begin
            ext_irq_reg <= 16'h0000;
        end else begin
            ext_irq_reg <= ext_irq_next;
        end
    end
    assign ext_irq_line = ext_irq_reg;

    // checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    property p_t2_route;
        (dma_req_in.second_single_timer_update_request
         && !dma_req_in.converter_request && !$past(rst))
        |=> dma_chan_req[1] != $past(cfg_reg[SCRB_BIT_T2_RMP]);
    endproperty
    a_t2_route: assert property (p_t2_route) else $error("t2 route");

    property p_t1_route;
        (dma_req_in.first_single_timer_channel_request
         && !dma_req_in.serial_transmit_request
         && !dma_req_in.serial_receive_request && cfg_reg[SCRB_BIT_T1_RMP])
        |=> dma_chan_req[4] && !dma_chan_req[5];
    endproperty
    a_t1_route: assert property (p_t1_route) else $error("t1 route");

    property p_rx_route;
        dma_req_in.serial_receive_request && cfg_reg[SCRB_BIT_RX_RMP]
        |=> dma_chan_req[5];
    endproperty
    a_rx_route: assert property (p_rx_route) else $error("rx route");

    property p_tx_route;
        (dma_req_in.serial_transmit_request && !cfg_reg[SCRB_BIT_TX_RMP])
        |=> dma_chan_req[2];
    endproperty
    a_tx_route: assert property (p_tx_route) else $error("tx route");

    property p_adc_route;
        (dma_req_in == scrb_dma_req_s'(7'h01)) && !cfg_reg[SCRB_BIT_ADC_RMP]
        |=> dma_chan_req == 5'h01;
    endproperty
    a_adc_route: assert property (p_adc_route) else $error("adc route");

    property p_mem_ram;
        cfg_reg[1:0] == 2'b11 |-> mem_select == SCRB_MEM_RAM;
    endproperty
    a_mem_ram: assert property (p_mem_ram) else $error("mem select");

    property p_boot_load;
        $fell(boot_pend_reg) && !$past(wr_en)
        |-> cfg_reg[1:0] == $past(boot_mem);
    endproperty
    a_boot_load: assert property (p_boot_load) else $error("boot load");

    property p_write_cfg;
        wr_en && idx == 3'h1 && pstrb == 4'hf
        |=> cfg_reg == ($past(pwdata) & SCRB_CFG_MASK);
    endproperty
    a_write_cfg: assert property (p_write_cfg) else $error("cfg write");

    property p_read_sel;
        rd_setup && idx == 3'h3 |=> prdata[31:16] == 16'h0000 ##0
            prdata[15:0] == $past(src_sel_reg[1][15:0]);
    endproperty
    a_read_sel: assert property (p_read_sel) else $error("sel read");

    property p_line0_pd;
        src_sel_reg[0][3:0] == SCRB_SRC_PD |=> ext_irq_line[0]
            == $past(pd_sync_reg[0]);
    endproperty
    a_line0_pd: assert property (p_line0_pd) else $error("line 0");

    property p_line15_off;
        src_sel_reg[3][15:12] > SCRB_SRC_PD |=> !ext_irq_line[15];
    endproperty
    a_line15_off: assert property (p_line15_off) else $error("line 15");

endmodule : scrb_bank

// *** tb/tb_system_config_remap_bank.sv ***
// testbench: apb access, dma routing, boot memory select, irq source mux
module tb_system_config_remap_bank;
    timeunit 1ns;
    timeprecision 1ps;
    import scrb_pkg::*;

    // clock, reset and apb
    logic          core_clk;
    logic          rst;
    logic          psel;
    logic          penable;
    logic          pwrite;
    logic [7:0]    paddr;
    logic [31:0]   pwdata;
    logic [3:0]    pstrb;
    logic          pready;
    logic          pslverr;
    logic [31:0]   prdata;
    // straps, dma routing and irq sources
    logic          boot_select_pin;
    logic          inverted_boot_option_bit;
    scrb_dma_req_s dma_req_in;
    logic [5:1]    dma_chan_req;
    scrb_remap_s   remap_sel;
    scrb_mem_e     mem_select;
    logic [15:0]   gpio_port_a;
    logic [15:0]   gpio_port_b;
    logic [15:0]   gpio_port_c;
    logic [15:0]   gpio_port_d;
    logic [15:0]   ext_irq_line;
    // bookkeeping and tables
    int            fail_count;
    int            tests_run;
    logic [31:0]   rd_data;
    logic          rd_err;
    logic [3:0]    strb_val;
    logic [5:1]    exp_dma;
    logic [15:0]   exp_irq;
    logic [6:0]    req;
    scrb_mem_e     mem_tab [4] = '{SCRB_MEM_MAIN, SCRB_MEM_SYSTEM,
                                   SCRB_MEM_MAIN, SCRB_MEM_RAM};
    logic [4:0]    rmp_tab [4] = '{5'h00, 5'h1f, 5'h15, 5'h0a};
    logic [63:0]   sel_tab [6] = '{64'h0000_0000_0000_0000,
                                   64'h1111_1111_1111_1111,
                                   64'h2222_2222_2222_2222,
                                   64'h3333_3333_3333_3333,
                                   64'h4f4f_5a6b_c7d8_e9f4,
                                   64'h0123_3210_4f21_3012};

    // device under test
    scrb_bank u_dut (
        .core_clk                 (core_clk),
        .rst                      (rst),
        .psel                     (psel),
        .penable                  (penable),
        .pwrite                   (pwrite),
        .paddr                    (paddr),
        .pwdata                   (pwdata),
        .pstrb                    (pstrb),
        .pready                   (pready),
        .pslverr                  (pslverr),
        .prdata                   (prdata),
        .boot_select_pin          (boot_select_pin),
        .inverted_boot_option_bit (inverted_boot_option_bit),
        .dma_req_in               (dma_req_in),
        .dma_chan_req             (dma_chan_req),
        .remap_sel                (remap_sel),
        .mem_select               (mem_select),
        .gpio_port_a              (gpio_port_a),
        .gpio_port_b              (gpio_port_b),
        .gpio_port_c              (gpio_port_c),
        .gpio_port_d              (gpio_port_d),
        .ext_irq_line             (ext_irq_line)
    );

    // 100 mhz clock
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    // compare and count
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // counts and verdict, then stop
    task automatic report_and_stop;
        $display("checks %0d, mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : report_and_stop

    // one apb transfer: setup, access held until pready
    task automatic apb_xfer(input logic wr, input logic [7:0] addr,
                            input logic [31:0] data);
        @(posedge core_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= addr;
        pwdata  <= data;
        pstrb   <= strb_val;
        @(posedge core_clk);
        penable <= 1'b1;
        @(posedge core_clk);
        while (pready !== 1'b1) @(posedge core_clk);
        rd_data = prdata;
        rd_err  = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        #1;
    endtask : apb_xfer

    // read a register and compare
    task automatic rd_chk(input logic [7:0] addr, input logic [31:0] exp);
        apb_xfer(1'b0, addr, 32'h0000_0000);
        check(rd_data, exp);
    endtask : rd_chk

    // synchronous reset with given boot straps
    task automatic do_reset(input logic bp, input logic opt);
        @(posedge core_clk);
        boot_select_pin          <= bp;
        inverted_boot_option_bit <= opt;
        rst                      <= 1'b1;
        repeat (6) @(posedge core_clk);
        rst <= 1'b0;
        repeat (2) @(posedge core_clk);
    endtask : do_reset

    // expected dma channel requests for requests r and remap bits m
    function automatic logic [5:1] route(input logic [6:0] r,
                                         input logic [4:0] m);
        logic       t2;
        logic       t1;
        logic [5:1] c;
        t2   = r[6] | r[5];
        t1   = r[4] | r[3];
        c[1] = (t2 & ~m[4]) | (r[0] & ~m[0]);
        c[2] = (t2 & m[4]) | (r[1] & ~m[1]) | (r[0] & m[0]);
        c[3] = (t1 & ~m[3]) | (r[2] & ~m[2]);
        c[4] = (t1 & m[3]) | (r[1] & m[1]);
        c[5] = r[2] & m[2];
        return c;
    endfunction : route

    // expected irq lines for sixteen packed selectors
    function automatic logic [15:0] irq_exp(input logic [63:0] sel);
        logic [15:0] e;
        logic [3:0]  c;
        for (int i = 0; i < 16; i++) begin
            c    = sel[4*i +: 4];
            e[i] = (c == 4'h0) ? gpio_port_a[i] : (c == 4'h1) ? gpio_port_b[i]
                 : (c == 4'h2) ? gpio_port_c[i] : (c == 4'h3) ? gpio_port_d[i]
                 : 1'b0;
        end
        return e;
    endfunction : irq_exp

    // watchdog against a hung handshake
    initial begin
        repeat (20000) @(posedge core_clk);
        fail_count++;
        report_and_stop();
    end

    // main test sequence
    initial begin
        {rst, psel, penable, pwrite} = 4'b1000;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        pstrb = 4'hf;
        strb_val = 4'hf;
        boot_select_pin = 1'b0;
        inverted_boot_option_bit = 1'b0;
        dma_req_in = '0;
        {gpio_port_a, gpio_port_b} = {16'h00ff, 16'h0f0f};
        {gpio_port_c, gpio_port_d} = {16'h3333, 16'h5555};
        fail_count = 0;
        tests_run = 0;
        do_reset(1'b1, 1'b0);
        rd_chk(SCRB_OFS_CFG, 32'h0000_0003);
        check(32'(mem_select), 32'(SCRB_MEM_RAM));
        for (int k = 0; k < 4; k++)
            rd_chk(8'(SCRB_OFS_SEL0 + 4 * k), 32'h0000_0000);
        apb_xfer(1'b1, SCRB_OFS_CFG, 32'hffff_ffff);
        rd_chk(SCRB_OFS_CFG, 32'h0000_1f03);
        check(32'(rd_err), 32'h0000_0000);
        // byte strobes: only the low lane is written
        strb_val = 4'h1;
        apb_xfer(1'b1, SCRB_OFS_CFG, 32'h0000_0000);
        strb_val = 4'hf;
        rd_chk(SCRB_OFS_CFG, 32'h0000_1f00);
        apb_xfer(1'b1, 8'h04, 32'hffff_ffff);
        rd_chk(8'h04, 32'h0000_0000);
        check(32'(rd_err), 32'h0000_0001);
        // memory select codes, overriding the boot value
        for (int c = 0; c < 4; c++) begin
            apb_xfer(1'b1, SCRB_OFS_CFG, 32'(c));
            rd_chk(SCRB_OFS_CFG, 32'(c));
            check(32'(mem_select), 32'(mem_tab[c]));
        end
        // dma routing for each remap setting and request
        foreach (rmp_tab[s]) begin
            apb_xfer(1'b1, SCRB_OFS_CFG, {19'h0, rmp_tab[s], 8'h00});
            check(32'(remap_sel), 32'(rmp_tab[s]));
            for (int i = 0; i < 8; i++) begin
                req = (i < 7) ? 7'(1 << i) : 7'h7f;
                @(posedge core_clk);
                dma_req_in <= scrb_dma_req_s'(req);
                repeat (2) @(posedge core_clk);
                #1;
                exp_dma = route(req, rmp_tab[s]);
                check(32'(dma_chan_req), 32'(exp_dma));
            end
        end
        @(posedge core_clk);
        dma_req_in <= '0;
        // irq source selection, pins toggled to follow live levels
        foreach (sel_tab[t]) begin
            for (int k = 0; k < 4; k++)
                apb_xfer(1'b1, 8'(SCRB_OFS_SEL0 + 4 * k),
                         {16'h0000, sel_tab[t][16*k +: 16]});
            repeat (2) begin
                repeat (4) @(posedge core_clk);
                #1;
                exp_irq = irq_exp(sel_tab[t]);
                check(32'(ext_irq_line), 32'(exp_irq));
                @(posedge core_clk);
                {gpio_port_a, gpio_port_b, gpio_port_c, gpio_port_d} <=
                    ~{gpio_port_a, gpio_port_b, gpio_port_c, gpio_port_d};
            end
        end
        // selector registers are distinct and keep only bits 15:0
        for (int k = 0; k < 4; k++)
            apb_xfer(1'b1, 8'(SCRB_OFS_SEL0 + 4 * k), 32'(32'hffff_4321 + k));
        for (int k = 0; k < 4; k++)
            rd_chk(8'(SCRB_OFS_SEL0 + 4 * k), 32'(32'h0000_4321 + k));
        // second and third reset with other boot straps
        do_reset(1'b0, 1'b0);
        rd_chk(SCRB_OFS_CFG, 32'h0000_0000);
        check(32'(mem_select), 32'(SCRB_MEM_MAIN));
        rd_chk(SCRB_OFS_SEL3, 32'h0000_0000);
        do_reset(1'b1, 1'b1);
        rd_chk(SCRB_OFS_CFG, 32'h0000_0001);
        check(32'(mem_select), 32'(SCRB_MEM_SYSTEM));
        report_and_stop();
    end

endmodule : tb_system_config_remap_bank
